// ### hdl/clock_recovery.v
// Packet clock recovery: stamping, state tracking, oscillators, selectors
`timescale 1ns/1ns
`default_nettype none
`include "clock_recovery_defines.vh"

module clock_recovery #(
   parameter HOLD_CYCLES = `HOLD_CYCLES
) (
   input wire CLK_I,
   input wire RST_I,
   input wire PKT_VALID_I,
   input wire PKT_TIMING_I,
   input wire [1:0] PKT_CHAN_I,
   input wire PKT_HAS_TS_I,
   input wire [31:0] PKT_TS_I,
   input wire [15:0] PKT_SEQ_I,
   input wire [15:0] PKT_INCR_I,
   input wire PKT_GOOD_I,
   input wire COMMON_REF_I,
   input wire [3:0] DIFF_MODE_I,
   input wire [3:0] LOCK_OK_I,
   input wire [3:0] ASSESS_BAD_I,
   input wire FREQ_WE_I,
   input wire [1:0] FREQ_CHAN_I,
   input wire [31:0] FREQ_WORD_I,
   input wire [1:0] REF_SEL_I,
   input wire [1:0] TS_SEL_I,
   output reg STAMP_VALID_O,
   output reg [1:0] STAMP_CHAN_O,
   output reg [31:0] STAMP_ARRIVAL_O,
   output reg [31:0] STAMP_LAUNCH_O,
   output reg [31:0] STAMP_DELTA_O,
   output reg FREQ_REJECT_O,
   output wire [15:0] STATE_O,
   output wire [3:0] LOSS_OF_LOCK_O,
   output reg RECOVERED_REF_OUT_O,
   output reg REPEATER_TS_CLK_O
);
   localparam [3:0] ST_FREE = 4'h1;
   localparam [3:0] ST_ACQUIRING = 4'h2;
   localparam [3:0] ST_ACQUIRED = 4'h4;
   localparam [3:0] ST_HOLDOVER = 4'h8;
   localparam [31:0] hold_last = HOLD_CYCLES - 1;

   reg [31:0] sys_time_reg;
   reg [31:0] ref_time_reg;
   reg ref_prev_reg;
   reg [1:0] rd_chan_reg;
   reg [1:0] acc_chan_reg;
   wire [3:0] clk_bit;
   wire [3:0] frozen;
   reg [31:0] arrival_next;
   reg [31:0] launch_next;
   wire [31:0] mem_rd_data;
   wire [31:0] eff_launch;
   wire pkt_timing;
   wire wr_ok;

   assign pkt_timing = PKT_VALID_I & PKT_TIMING_I;
   // Sequence count scaled by the PKT_INCR_I payload size given with each packet
   assign eff_launch = PKT_SEQ_I * PKT_INCR_I;
   assign wr_ok = FREQ_WE_I & ~frozen[FREQ_CHAN_I];

   // Local time bases: system clock and common reference edges
   always @(posedge CLK_I) begin
      if (RST_I) begin
         sys_time_reg <= `TIME_RESET;
         ref_time_reg <= `TIME_RESET;
         ref_prev_reg <= 1'b0;
      end else begin
         sys_time_reg <= sys_time_reg + 32'h0000_0001;
         ref_prev_reg <= COMMON_REF_I;
         if (COMMON_REF_I && !ref_prev_reg) begin
            ref_time_reg <= ref_time_reg + 32'h0000_0001;
         end
      end
   end

   always @* begin
      arrival_next = sys_time_reg;
      if (DIFF_MODE_I[PKT_CHAN_I]) begin
         arrival_next = ref_time_reg;
      end
      launch_next = PKT_TS_I;
      if (!PKT_HAS_TS_I) begin
         launch_next = eff_launch;
      end
   end

   // Arrival stamp and launch time share one record for the host filter
   always @(posedge CLK_I) begin
      if (RST_I) begin
         STAMP_VALID_O <= 1'b0;
         STAMP_CHAN_O <= 2'h0;
         STAMP_ARRIVAL_O <= `TIME_RESET;
         STAMP_LAUNCH_O <= `TIME_RESET;
         STAMP_DELTA_O <= `TIME_RESET;
      end else begin
         STAMP_VALID_O <= pkt_timing;
         if (pkt_timing) begin
            STAMP_CHAN_O <= PKT_CHAN_I;
            STAMP_ARRIVAL_O <= arrival_next;
            STAMP_LAUNCH_O <= launch_next;
            STAMP_DELTA_O <= arrival_next - launch_next;
         end
      end
   end

   always @(posedge CLK_I) begin
      if (RST_I) begin
         FREQ_REJECT_O <= 1'b0;
      end else begin
         FREQ_REJECT_O <= FREQ_WE_I & ~wr_ok;
      end
   end

   freq_word_mem u_freq_mem (
      .clk_i(CLK_I),
      .rst_i(RST_I),
      .wr_en_i(wr_ok),
      .wr_addr_i(FREQ_CHAN_I),
      .wr_data_i(FREQ_WORD_I),
      .rd_addr_i(rd_chan_reg),
      .rd_data_o(mem_rd_data)
   );

   // Memory has one read port, so the oscillators step in turn
   always @(posedge CLK_I) begin
      if (RST_I) begin
         rd_chan_reg <= 2'h0;
         acc_chan_reg <= 2'h0;
      end else begin
         rd_chan_reg <= rd_chan_reg + 2'h1;
         acc_chan_reg <= rd_chan_reg;
      end
   end

   genvar i;
   generate
      for (i = 0; i < `NUM_CHAN; i = i + 1) begin : g_chan
         reg [3:0] state_reg;
         reg [3:0] state_next;
         reg freeze_reg;
         reg [31:0] bad_cnt_reg;
         reg [31:0] phase_reg;
         reg lol_reg;
         wire hit;

         assign hit = pkt_timing && PKT_CHAN_I == i;
         assign STATE_O[4 * i + 3:4 * i] = state_reg;
         assign LOSS_OF_LOCK_O[i] = lol_reg;
         assign clk_bit[i] = phase_reg[31];
         assign frozen[i] = freeze_reg;

         always @* begin
            state_next = state_reg;
            case (state_reg)
               ST_FREE: begin
                  if (hit) begin
                     state_next = ST_ACQUIRING;
                  end
               end
               ST_ACQUIRING: begin
                  if (bad_cnt_reg == hold_last && ASSESS_BAD_I[i]) begin
                     state_next = ST_HOLDOVER;
                  end else if (LOCK_OK_I[i] && !ASSESS_BAD_I[i]) begin
                     state_next = ST_ACQUIRED;
                  end
               end
               ST_ACQUIRED: begin
                  if (ASSESS_BAD_I[i]) begin
                     state_next = ST_ACQUIRING;
                  end
               end
               ST_HOLDOVER: begin
                  if (hit && PKT_GOOD_I) begin
                     state_next = ST_ACQUIRING;
                  end
               end
               default: begin
                  state_next = ST_FREE;
               end
            endcase
         end

         always @(posedge CLK_I) begin
            if (RST_I) begin
               state_reg <= ST_FREE;
               freeze_reg <= 1'b0;
               bad_cnt_reg <= 32'h0000_0000;
               lol_reg <= 1'b0;
            end else begin
               state_reg <= state_next;
               lol_reg <= state_reg == ST_ACQUIRING &&
                  state_next == ST_HOLDOVER;
               if (state_reg == ST_ACQUIRED && state_next == ST_ACQUIRING) begin
                  freeze_reg <= 1'b1;
               end else if (state_next == ST_ACQUIRED) begin
                  freeze_reg <= 1'b0;
               end
               // Holdover counts only while acquiring and unable to assess
               if (state_reg == ST_ACQUIRING && ASSESS_BAD_I[i] &&
                   bad_cnt_reg != hold_last) begin
                  bad_cnt_reg <= bad_cnt_reg + 32'h0000_0001;
               end else if (!(state_reg == ST_ACQUIRING &&
                              ASSESS_BAD_I[i])) begin
                  bad_cnt_reg <= 32'h0000_0000;
               end
            end
         end

         // Numerically controlled oscillator, MSB is the recovered clock
         always @(posedge CLK_I) begin
            if (RST_I) begin
               phase_reg <= 32'h0000_0000;
            end else if (acc_chan_reg == i) begin
               phase_reg <= phase_reg + mem_rd_data;
            end
         end
      end
   endgenerate

   // No glitch-free switchover; an external PLL must hide the phase step
   always @(posedge CLK_I) begin
      if (RST_I) begin
         RECOVERED_REF_OUT_O <= 1'b0;
         REPEATER_TS_CLK_O <= 1'b0;
      end else begin
         RECOVERED_REF_OUT_O <= clk_bit[REF_SEL_I];
         REPEATER_TS_CLK_O <= clk_bit[TS_SEL_I];
      end
   end
endmodule

`default_nettype wire

// ### hdl/clock_recovery_defines.vh
// Constants for the packet clock recovery support block
// Behaviour
// - Four clocks, one selected onto reference pin
// - Separate selector feeds repeater timestamp clock
// - Switching clocks may cause phase transient
// - Timing packets stamped with comparable arrival time
// - Sequence number yields effective launch time
// - Start free running; frequency presettable
// - Packets in free run start acquiring
// - Acquired only when frequency and phase locked
// - Lost assessment: back to acquiring, freeze
// - Acquiring too long: holdover, loss-of-lock interrupt (code counts only cycles with ASSESS_BAD_I high)
// - Good packets in holdover resume acquiring
// - Host filter output sets oscillator frequency
// - Adaptive mode stamps on local system time
// - Differential mode stamps on common reference
`ifndef CLOCK_RECOVERY_DEFINES_VH
`define CLOCK_RECOVERY_DEFINES_VH

`define NUM_CHAN 4
`define TIME_W 32
`define FREQ_RESET 32'h0000_0000
`define TIME_RESET 32'h0000_0000
`define HOLD_TIMEOUT_MS 1000
`define CLK_KHZ 10000
`define HOLD_CYCLES (`HOLD_TIMEOUT_MS * `CLK_KHZ)

`endif

// ### hdl/freq_word_mem.v
// Frequency control words of the four oscillators
`timescale 1ns/1ns
`default_nettype none
`include "clock_recovery_defines.vh"

module freq_word_mem (
   input wire clk_i,
   input wire rst_i,
   input wire wr_en_i,
   input wire [1:0] wr_addr_i,
   input wire [31:0] wr_data_i,
   input wire [1:0] rd_addr_i,
   output reg [31:0] rd_data_o
);
   // One register per word keeps a single writer for each
   wire [127:0] words;
   genvar i;

   generate
      for (i = 0; i < 4; i = i + 1) begin : g_word
         reg [31:0] word_reg;
         assign words[32 * i + 31:32 * i] = word_reg;
         always @(posedge clk_i) begin
            if (rst_i) begin
               word_reg <= `FREQ_RESET;
            end else if (wr_en_i && wr_addr_i == i) begin
               word_reg <= wr_data_i;
            end
         end
      end
   endgenerate

   always @(posedge clk_i) begin
      if (rst_i) begin
         rd_data_o <= `FREQ_RESET;
      end else begin
         rd_data_o <= words[32 * rd_addr_i +: 32];
      end
   end
endmodule

`default_nettype wire

// ### tb/clock_recovery_assertions.sv
// Port-level assertions for the clock recovery block
`timescale 1ns/1ns
`default_nettype none
module clock_recovery_assertions(
   input wire CLK_I,
   input wire RST_I,
   input wire PKT_VALID_I,
   input wire PKT_TIMING_I,
   input wire [1:0] PKT_CHAN_I,
   input wire STAMP_VALID_O,
   input wire [1:0] STAMP_CHAN_O,
   input wire [15:0] STATE_O,
   input wire [3:0] LOSS_OF_LOCK_O
);
   wire tp = PKT_VALID_I && PKT_TIMING_I;
   default clocking @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   AST_STAMP: assert property (tp |=> STAMP_VALID_O)
      else $error("stamp missing");
   AST_CHAN: assert property (
      tp |=> STAMP_CHAN_O == $past(PKT_CHAN_I)) else $error("stamp chan");
   AST_WAKE: assert property (
      tp && PKT_CHAN_I == 2'h0 && STATE_O[0] |=> STATE_O[1])
      else $error("no acquire");
   AST_ONEHOT: assert property ($onehot(STATE_O[3:0]))
      else $error("state code");
   AST_LOL: assert property (
      LOSS_OF_LOCK_O[0] == $rose(STATE_O[3])) else $error("lock pulse");
   AST_HOLD: assert property (
      $rose(STATE_O[3]) |-> $past(STATE_O[1])) else $error("hold entry");
   AST_ACQD: assert property (
      $rose(STATE_O[2]) |-> $past(STATE_O[1])) else $error("lock entry");
   AST_INIT: assert property ($fell(RST_I) |-> STATE_O == 16'h1111)
      else $error("reset state");
endmodule
bind clock_recovery clock_recovery_assertions chk (.CLK_I, .RST_I,
   .PKT_VALID_I, .PKT_TIMING_I, .PKT_CHAN_I, .STAMP_VALID_O, .STAMP_CHAN_O,
   .STATE_O, .LOSS_OF_LOCK_O);
`default_nettype wire

// ### tb/timing_master_model.sv
// Remote timing master: one packet per request
`timescale 1ns/1ns
`default_nettype none
module timing_master_model(
   input wire logic clk_i,
   input wire logic send_i,
   input wire logic timing_i,
   input wire logic good_i,
   input wire logic [1:0] chan_i,
   output logic valid_o,
   output logic timing_o,
   output logic good_o,
   output logic has_ts_o,
   output logic [1:0] chan_o,
   output logic [15:0] seq_o,
   output logic [31:0] ts_o
);
   logic [15:0] seq_reg = 16'h0000;
   initial {valid_o, timing_o, good_o, has_ts_o, chan_o, seq_o, ts_o} = '0;
   always @(negedge clk_i) begin
      {valid_o, timing_o, good_o, chan_o} <= {send_i, timing_i, good_i, chan_i};
      // Idle fields flip so stale values are never trusted
      seq_o <= send_i ? seq_reg : ~seq_o;
      ts_o <= send_i ? {seq_reg, 16'h0000} : ~ts_o;
      has_ts_o <= seq_reg[0];
      seq_reg <= seq_reg + {15'h0000, send_i};
   end
endmodule
`default_nettype wire

// ### tb/clock_recovery_tb_top.sv
// Self-checking bench for the clock recovery block
`timescale 1ns/1ns
`default_nettype none
module clock_recovery_tb_top;
   logic CLK_I = 1'b0, RST_I = 1'b1, COMMON_REF_I = 1'b0, FREQ_WE_I = 1'b0;
   logic [1:0] FREQ_CHAN_I = 2'h0, REF_SEL_I = 2'h0, TS_SEL_I = 2'h0;
   logic [3:0] DIFF_MODE_I = 4'h0, LOCK_OK_I = 4'h0, ASSESS_BAD_I = 4'h0;
   logic [15:0] PKT_INCR_I = 16'h0001, PKT_SEQ_I, STATE_O;
   logic [31:0] FREQ_WORD_I = 32'h0000_0000, PKT_TS_I, exp_l, exp_a;
   logic [31:0] sys_m = 32'h0000_0000, ref_m = 32'h0000_0000;
   logic ref_q = 1'b0;
   logic PKT_VALID_I, PKT_TIMING_I, PKT_GOOD_I, PKT_HAS_TS_I, STAMP_VALID_O;
   logic FREQ_REJECT_O, RECOVERED_REF_OUT_O, REPEATER_TS_CLK_O;
   logic [1:0] PKT_CHAN_I, STAMP_CHAN_O, ch = 2'h0;
   logic [31:0] STAMP_ARRIVAL_O, STAMP_LAUNCH_O, STAMP_DELTA_O;
   logic [3:0] LOSS_OF_LOCK_O;
   logic send = 1'b0, tim = 1'b0, good = 1'b0;
   integer err_total = 0, total_checks = 0, i, seed = 32'h1444_e4c4;
   timing_master_model mst (.clk_i(CLK_I), .send_i(send), .timing_i(tim),
      .good_i(good), .chan_i(ch), .valid_o(PKT_VALID_I),
      .timing_o(PKT_TIMING_I), .good_o(PKT_GOOD_I), .has_ts_o(PKT_HAS_TS_I),
      .chan_o(PKT_CHAN_I), .seq_o(PKT_SEQ_I), .ts_o(PKT_TS_I));
   clock_recovery #(.HOLD_CYCLES(8)) DUT (.*);
   always #50 CLK_I = ~CLK_I;
   // Side pins wander so every stamp mode is exercised
   always @(negedge CLK_I) begin
      {PKT_INCR_I, DIFF_MODE_I, COMMON_REF_I} <= 21'($random(seed));
   end
   // Expected time bases for arrival stamps
   always @(posedge CLK_I) begin
      ref_q <= RST_I ? 1'b0 : COMMON_REF_I;
      sys_m <= RST_I ? 32'h0000_0000 : sys_m + 32'h0000_0001;
      ref_m <= RST_I ? 32'h0000_0000 : ref_m + 32'(COMMON_REF_I & ~ref_q);
   end
   task automatic chk(input string n, input logic [31:0] s, e);
      total_checks++;
      if (s !== e) begin
         err_total++;
         $display("mismatch %s exp %h seen %h", n, e, s);
      end
   endtask
   task automatic pkt(input logic [1:0] c, input logic t, g);
      @(negedge CLK_I);
      {send, ch, tim, good} <= {1'b1, c, t, g};
      @(negedge CLK_I);
      send <= 1'b0;
      @(posedge CLK_I);
      exp_l = PKT_HAS_TS_I ? PKT_TS_I : PKT_SEQ_I * PKT_INCR_I;
      exp_a = DIFF_MODE_I[c] ? ref_m : sys_m;
      @(negedge CLK_I);
      chk("stamp", STAMP_VALID_O, t);
      if (t) begin
         chk("chan", STAMP_CHAN_O, c);
         chk("launch", STAMP_LAUNCH_O, exp_l);
         chk("arrival", STAMP_ARRIVAL_O, exp_a);
         chk("delta", STAMP_DELTA_O, exp_a - exp_l);
      end
   endtask
   task automatic fw(input logic [1:0] c, input logic [31:0] w,
         input logic e);
      @(negedge CLK_I);
      {FREQ_WE_I, FREQ_CHAN_I, FREQ_WORD_I} <= {1'b1, c, w};
      @(negedge CLK_I);
      FREQ_WE_I <= 1'b0;
      chk("reject", FREQ_REJECT_O, e);
   endtask
   // Counts output changes over 16 cycles for the chosen selections
   task automatic sel(input logic [1:0] r, t, input logic [4:0] er, et);
      logic [4:0] nr, nt;
      logic pr, pt;
      @(negedge CLK_I);
      {REF_SEL_I, TS_SEL_I} <= {r, t};
      repeat (3) @(negedge CLK_I);
      {nr, nt, pr, pt} = {10'h000, RECOVERED_REF_OUT_O, REPEATER_TS_CLK_O};
      repeat (16) begin
         @(negedge CLK_I);
         nr += 5'(RECOVERED_REF_OUT_O != pr);
         nt += 5'(REPEATER_TS_CLK_O != pt);
         {pr, pt} = {RECOVERED_REF_OUT_O, REPEATER_TS_CLK_O};
      end
      chk("ref sel", nr, er);
      chk("ts sel", nt, et);
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (8) @(negedge CLK_I);
      chk("reset", STATE_O, 16'h1111);
      RST_I <= 1'b0;
      fw(2'h0, $random(seed), 1'b0);
      $display("test reset done");
      pkt(2'h0, 1'b1, 1'b0);
      chk("acquire", STATE_O[3:0], 4'h2);
      for (i = 0; i < 40; i++)
         pkt(2'($random(seed)), 1'($random(seed)), 1'b0);
      $display("test stamp done");
      LOCK_OK_I <= 4'h1;
      @(negedge CLK_I);
      LOCK_OK_I <= 4'h0;
      chk("locked", STATE_O[3:0], 4'h4);
      ASSESS_BAD_I <= 4'h1;
      @(negedge CLK_I);
      chk("fallback", STATE_O[3:0], 4'h2);
      fw(2'h0, 32'h0000_0100, 1'b1);
      repeat (10) @(negedge CLK_I);
      chk("holdover", STATE_O[3:0], 4'h8);
      ASSESS_BAD_I <= 4'h0;
      // Freeze is only lifted by a new lock, so holdover still refuses
      fw(2'h0, 32'h0000_0100, 1'b1);
      pkt(2'h0, 1'b1, 1'b0);
      chk("stay", STATE_O[3:0], 4'h8);
      pkt(2'h0, 1'b1, 1'b1);
      chk("resume", STATE_O[3:0], 4'h2);
      $display("test states done");
      // Half-turn word flips the clock on each 4-cycle step; zero never does
      fw(2'h1, 32'h8000_0000, 1'b0);
      fw(2'h2, 32'h0000_0000, 1'b0);
      sel(2'h1, 2'h2, 5'h04, 5'h00);
      sel(2'h2, 2'h1, 5'h00, 5'h04);
      $display("test select done");
      end_sim;
   end
   // Whole run is near 200 cycles; far more means a hang
   initial begin
      #(100 * 3000);
      err_total++;
      end_sim;
   end
endmodule
`default_nettype wire
